// ### lmtu_pkg.sv
package lmtu_pkg;

   localparam int LMTU_LINES = 4;

   // timing
   localparam int CLK_HZ            = 50_000_000;
   localparam int PULSE_GAP_US      = 1000;
   localparam int PULSE_GAP_CYCLES  = (CLK_HZ / 1_000_000) * PULSE_GAP_US;
   localparam int M_FRAMES          = 8;

   // command/indication codes
   localparam logic [3:0] CMD_DEACTIVATION_REQUEST   = 4'h0;
   localparam logic [3:0] CMD_ANALOG_LOOP_REQUEST    = 4'h2;
   localparam logic [3:0] CMD_SINGLE_PULSE_TEST      = 4'h5;
   localparam logic [3:0] CMD_DATA_THROUGH_MODE      = 4'h6;
   localparam logic [3:0] CMD_ACTIVATION_REQUEST     = 4'h8;
   localparam logic [3:0] CMD_REPEATER_LOOP_REQUEST  = 4'h9;
   localparam logic [3:0] CMD_NT_LOOP_TWO_REQUEST    = 4'hA;

   // activation states reported by the line state machine
   localparam logic [2:0] ACT_DEACTIVATED     = 3'h0;
   localparam logic [2:0] ACT_SYNC_NO_TERM    = 3'h1;
   localparam logic [2:0] ACT_TERM_SYNC       = 3'h2;
   localparam logic [2:0] ACT_WAIT_1MS        = 3'h3;
   localparam logic [2:0] ACT_TRANSPARENT     = 3'h4;

   typedef enum logic [2:0] {
      MODE_NORMAL = 3'b000,
      MODE_NT2    = 3'b001,
      MODE_REP    = 3'b011,
      MODE_ANALOG = 3'b010,
      MODE_SSP    = 3'b110,
      MODE_DT     = 3'b111
   } lmtu_mode_type;

   // register byte offsets
   localparam logic [7:0] REG_LINE_PORT_CHOICE = 8'h00;
   localparam logic [7:0] REG_LOOP             = 8'h04;
   localparam logic [7:0] REG_ERR_CHAN_SELECT  = 8'h08;
   localparam logic [7:0] REG_BIT_ERR_LO       = 8'h0C;
   localparam logic [7:0] REG_BIT_ERR_HI       = 8'h10;
   localparam logic [7:0] REG_BLOCK_ERR        = 8'h14;
   localparam logic [7:0] REG_STATUS           = 8'h18;

   // loop register field positions
   localparam int LOOP_BEARER_ONE  = 0;
   localparam int LOOP_BEARER_TWO  = 1;
   localparam int LOOP_ALL_CHAN    = 2;
   localparam int LOOP_DIRECTION   = 3;
   localparam int LOOP_PASS_THRU   = 4;
   localparam int LOOP_FRAMER      = 5;
   localparam int LOOP_WIDTH       = 6;
   localparam logic [5:0] LOOP_RESET = 6'h00;

   // error channel selection codes
   localparam logic [1:0] BER_OFF    = 2'h0;
   localparam logic [1:0] BER_B1     = 2'h1;
   localparam logic [1:0] BER_B2     = 2'h2;
   localparam logic [1:0] BER_ALL    = 2'h3;

   localparam logic [7:0]  BLOCK_ERR_MAX = 8'hFF;
   localparam logic [15:0] BIT_ERR_MAX   = 16'hFFFF;

   typedef struct packed {
      logic [7:0] b1;
      logic [7:0] b2;
      logic [1:0] d;
   } lmtu_chan_type;

   localparam lmtu_chan_type CHAN_IDLE = '{b1: 8'hFF, b2: 8'hFF, d: 2'h3};

endpackage

// ### lmtu_line_maint.sv
`timescale 1ns/1ps

module lmtu_line_maint
   import lmtu_pkg::*;
#(
   parameter int PULSE_CYCLES = PULSE_GAP_CYCLES
) (
   input  wire logic                  clk_sys,
   input  wire logic                  rst_n,
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   input  wire logic                  wb_we_i,
   input  wire logic [7:0]            wb_adr_i,
   input  wire logic [3:0]            wb_sel_i,
   input  wire logic [31:0]           wb_dat_i,
   output logic      [31:0]           wb_dat_o,
   output logic                       wb_ack_o,
   input  wire logic                  cmd_valid,
   input  wire logic [1:0]            cmd_line,
   input  wire logic [3:0]            cmd_code,
   input  wire logic                  mon_rd_valid,
   input  wire logic [1:0]            mon_rd_line,
   output logic                       mon_rd_ack,
   output logic      [7:0]            mon_rd_data,
   input  wire logic                  single_pulse_pin,
   input  wire logic                  data_through_pin,
   input  wire logic                  digital_if_active,
   input  wire logic [3:0]            frame_strobe,
   input  wire logic [3:0]            frame_code_violation,
   input  wire logic [3:0]            rx_m_plus,
   input  wire logic [2:0]            act_state [LMTU_LINES],
   input  wire lmtu_chan_type         sys_in    [LMTU_LINES],
   input  wire lmtu_chan_type         line_in   [LMTU_LINES],
   output lmtu_chan_type              sys_out   [LMTU_LINES],
   output lmtu_chan_type              line_out  [LMTU_LINES],
   output logic      [3:0]            tx_m_plus,
   output logic      [3:0]            tx_enable,
   output logic      [3:0]            analog_loop_en,
   output logic      [3:0]            far_end_ignore,
   output logic      [3:0]            force_transparent,
   output logic      [3:0]            single_pulse_tx,
   output logic      [3:0]            activation_block
);

   function automatic logic [4:0] count_ones(input lmtu_chan_type c, input logic [1:0] sel);
      logic [4:0] n;
      n = 5'h00;
      for (int i = 0; i < 8; i++) begin
         if (sel == BER_B1 || sel == BER_ALL) begin
            n = n + 5'(c.b1[i]);
         end
         if (sel == BER_B2 || sel == BER_ALL) begin
            n = n + 5'(c.b2[i]);
         end
      end
      if (sel == BER_ALL) begin
         n = n + 5'(c.d[0]) + 5'(c.d[1]);
      end
      return n;
   endfunction

   function automatic logic active_count_state(input logic [2:0] s);
      return (s == ACT_SYNC_NO_TERM) || (s == ACT_TERM_SYNC) ||
             (s == ACT_WAIT_1MS) || (s == ACT_TRANSPARENT);
   endfunction

   // chooses per channel between a normal and a looped source
   function automatic lmtu_chan_type chan_mux(input lmtu_chan_type norm, input lmtu_chan_type alt,
                                              input logic m1, input logic m2, input logic md);
      lmtu_chan_type r;
      r.b1 = m1 ? alt.b1 : norm.b1;
      r.b2 = m2 ? alt.b2 : norm.b2;
      r.d  = md ? alt.d  : norm.d;
      return r;
   endfunction

   // pin synchronisers
   logic [1:0]             ssp_sync_q;
   logic [1:0]             dt_sync_q;
   logic                   ssp_pin_eff;
   logic                   dt_pin_eff;

   lmtu_mode_type          mode_q      [LMTU_LINES];
   logic [3:0]             m_cnt_q     [LMTU_LINES];
   logic [LOOP_WIDTH-1:0]  loop_q      [LMTU_LINES];
   logic [1:0]             ber_sel_q   [LMTU_LINES];
   logic [15:0]            bit_err_q   [LMTU_LINES];
   logic [7:0]             blk_err_q   [LMTU_LINES];
   logic [3:0]             block_q;
   logic [1:0]             line_sel_q;
   logic [7:0]             bit_hi_snap_q;
   logic [15:0]            pulse_cnt_q;
   logic                   pulse_tick;
   logic                   wb_req;
   logic                   wb_wr;
   logic                   wb_rd;
   logic [3:0]             blk_clr;
   logic [3:0]             bit_clr;
   logic [3:0]             loop_two_closed;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ssp_sync_q <= 2'h0;
         dt_sync_q  <= 2'h0;
      end else begin
         ssp_sync_q <= {ssp_sync_q[0], single_pulse_pin};
         dt_sync_q  <= {dt_sync_q[0], data_through_pin};
      end
   end

   assign ssp_pin_eff = ssp_sync_q[1] & digital_if_active;
   assign dt_pin_eff  = dt_sync_q[1] & digital_if_active;

   // wishbone slave, one wait state
   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wb_wr  = wb_req & wb_we_i & wb_sel_i[0];
   assign wb_rd  = wb_req & ~wb_we_i;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_req;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wb_dat_o      <= 32'h0000_0000;
         bit_hi_snap_q <= 8'h00;
      end else if (wb_rd) begin
         case (wb_adr_i)
            REG_LINE_PORT_CHOICE: wb_dat_o <= {30'h0, line_sel_q};
            REG_LOOP:             wb_dat_o <= {26'h0, loop_q[line_sel_q]};
            REG_ERR_CHAN_SELECT:  wb_dat_o <= {30'h0, ber_sel_q[line_sel_q]};
            REG_BIT_ERR_LO: begin
               wb_dat_o      <= {24'h0, bit_err_q[line_sel_q][7:0]};
               bit_hi_snap_q <= bit_err_q[line_sel_q][15:8];
            end
            REG_BIT_ERR_HI:       wb_dat_o <= {24'h0, bit_hi_snap_q};
            REG_BLOCK_ERR:        wb_dat_o <= {24'h0, blk_err_q[line_sel_q]};
            REG_STATUS: begin
               wb_dat_o <= {22'h0, force_transparent[line_sel_q], single_pulse_tx[line_sel_q],
                            loop_two_closed[line_sel_q], analog_loop_en[line_sel_q],
                            block_q[line_sel_q], tx_m_plus[line_sel_q], 1'b0, mode_q[line_sel_q]};
            end
            default:              wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         line_sel_q <= 2'h0;
      end else if (wb_wr && wb_adr_i == REG_LINE_PORT_CHOICE) begin
         line_sel_q <= wb_dat_i[1:0];
      end
   end

   // monitor read of the block error count
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mon_rd_ack  <= 1'b0;
         mon_rd_data <= 8'h00;
      end else begin
         mon_rd_ack <= mon_rd_valid;
         if (mon_rd_valid) begin
            mon_rd_data <= blk_err_q[mon_rd_line];
         end
      end
   end

   // 1 ms pulse tick shared by all lines
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pulse_cnt_q <= 16'h0000;
      end else if (pulse_tick) begin
         pulse_cnt_q <= 16'h0000;
      end else begin
         pulse_cnt_q <= pulse_cnt_q + 16'h0001;
      end
   end

   assign pulse_tick = (pulse_cnt_q == 16'(PULSE_CYCLES - 1));

   for (genvar l = 0; l < LMTU_LINES; l++) begin : g_line
      logic          ssp_on;
      logic          dt_on;
      logic          loop_sys;
      logic          loop_line;
      logic          m1;
      logic          m2;
      logic          md;
      logic          pass;
      logic          cmd_here;
      lmtu_chan_type fwd_line;
      lmtu_chan_type fwd_sys;

      assign cmd_here = cmd_valid && cmd_line == 2'(l);

      // command decode; accepted even while the pin forces data-through
      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            mode_q[l] <= MODE_NORMAL;
         end else if (cmd_here) begin
            case (cmd_code)
               CMD_ANALOG_LOOP_REQUEST:   mode_q[l] <= MODE_ANALOG;
               CMD_REPEATER_LOOP_REQUEST: mode_q[l] <= MODE_REP;
               CMD_NT_LOOP_TWO_REQUEST:   mode_q[l] <= MODE_NT2;
               CMD_ACTIVATION_REQUEST:    mode_q[l] <= MODE_NORMAL;
               CMD_DEACTIVATION_REQUEST:  mode_q[l] <= MODE_NORMAL;
               CMD_SINGLE_PULSE_TEST:     mode_q[l] <= MODE_SSP;
               CMD_DATA_THROUGH_MODE:     mode_q[l] <= MODE_DT;
               default:                   mode_q[l] <= mode_q[l];
            endcase
         end
      end

      // frames sent since the M pattern started
      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            m_cnt_q[l] <= 4'h0;
         end else if (cmd_here) begin
            m_cnt_q[l] <= 4'h0;
         end else if (frame_strobe[l] && m_cnt_q[l] != 4'(M_FRAMES)) begin
            m_cnt_q[l] <= m_cnt_q[l] + 4'h1;
         end
      end

      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            tx_m_plus[l] <= 1'b0;
         end else if (frame_strobe[l]) begin
            case (mode_q[l])
               MODE_REP: tx_m_plus[l] <= (m_cnt_q[l] < 4'(M_FRAMES)) && !m_cnt_q[l][0];
               MODE_NT2: tx_m_plus[l] <= 1'b1;
               default:  tx_m_plus[l] <= 1'b0;
            endcase
         end
      end

      // far end holds loop two after 8 plus symbols
      assign loop_two_closed[l] = (mode_q[l] == MODE_NT2) && (m_cnt_q[l] == 4'(M_FRAMES));

      assign ssp_on = ssp_pin_eff || mode_q[l] == MODE_SSP;
      assign dt_on  = dt_pin_eff || mode_q[l] == MODE_DT;

      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            single_pulse_tx[l]   <= 1'b0;
            force_transparent[l] <= 1'b0;
            analog_loop_en[l]    <= 1'b0;
            far_end_ignore[l]    <= 1'b0;
            tx_enable[l]         <= 1'b0;
         end else begin
            single_pulse_tx[l]   <= ssp_on & pulse_tick;
            force_transparent[l] <= dt_on;
            analog_loop_en[l]    <= mode_q[l] == MODE_ANALOG;
            far_end_ignore[l]    <= mode_q[l] == MODE_ANALOG || loop_q[l][LOOP_FRAMER];
            tx_enable[l]         <= !ssp_on;
         end
      end

      // local loop configuration
      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            loop_q[l]    <= LOOP_RESET;
            ber_sel_q[l] <= BER_OFF;
         end else if (wb_wr && line_sel_q == 2'(l)) begin
            if (wb_adr_i == REG_LOOP) begin
               loop_q[l] <= wb_dat_i[LOOP_WIDTH-1:0];
            end
            if (wb_adr_i == REG_ERR_CHAN_SELECT) begin
               ber_sel_q[l] <= wb_dat_i[1:0];
            end
         end
      end

      // framer loop chosen while deactivated blocks activation until released
      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            block_q[l] <= 1'b0;
         end else if (!loop_q[l][LOOP_FRAMER]) begin
            block_q[l] <= 1'b0;
         end else if (act_state[l] == ACT_DEACTIVATED) begin
            block_q[l] <= 1'b1;
         end
      end

      assign activation_block[l] = block_q[l];

      assign m1        = loop_q[l][LOOP_BEARER_ONE] | loop_q[l][LOOP_ALL_CHAN];
      assign m2        = loop_q[l][LOOP_BEARER_TWO] | loop_q[l][LOOP_ALL_CHAN];
      assign md        = loop_q[l][LOOP_ALL_CHAN];
      assign pass      = loop_q[l][LOOP_PASS_THRU];
      assign loop_sys  = !loop_q[l][LOOP_DIRECTION];
      assign loop_line = loop_q[l][LOOP_DIRECTION];
      assign fwd_line  = pass ? sys_in[l] : CHAN_IDLE;
      assign fwd_sys   = pass ? line_in[l] : CHAN_IDLE;

      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            sys_out[l]  <= CHAN_IDLE;
            line_out[l] <= CHAN_IDLE;
         end else if (frame_strobe[l]) begin
            if (mode_q[l] == MODE_ANALOG || loop_q[l][LOOP_FRAMER]) begin
               sys_out[l]  <= sys_in[l];
               line_out[l] <= sys_in[l];
            end else if (loop_sys) begin
               sys_out[l]  <= chan_mux(line_in[l], sys_in[l], m1, m2, md);
               line_out[l] <= chan_mux(sys_in[l], fwd_line, m1, m2, md);
            end else if (loop_line) begin
               sys_out[l]  <= chan_mux(line_in[l], fwd_sys, m1, m2, md);
               line_out[l] <= chan_mux(sys_in[l], line_in[l], m1, m2, md);
            end else begin
               sys_out[l]  <= line_in[l];
               line_out[l] <= sys_in[l];
            end
         end
      end

      assign blk_clr[l] = (wb_rd && wb_adr_i == REG_BLOCK_ERR && line_sel_q == 2'(l)) ||
                          (mon_rd_valid && mon_rd_line == 2'(l));
      assign bit_clr[l] = wb_rd && wb_adr_i == REG_BIT_ERR_LO && line_sel_q == 2'(l);

      // block error counter; a new error in the clearing cycle is kept
      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            blk_err_q[l] <= 8'h00;
         end else if (!active_count_state(act_state[l])) begin
            blk_err_q[l] <= 8'h00;
         end else if (frame_strobe[l] && (frame_code_violation[l] || rx_m_plus[l])) begin
            if (blk_clr[l]) begin
               blk_err_q[l] <= 8'h01;
            end else if (blk_err_q[l] != BLOCK_ERR_MAX) begin
               blk_err_q[l] <= blk_err_q[l] + 8'h01;
            end
         end else if (blk_clr[l]) begin
            blk_err_q[l] <= 8'h00;
         end
      end

      // bit error counter: received ones on selected channels
      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            bit_err_q[l] <= 16'h0000;
         end else if (frame_strobe[l] && loop_two_closed[l] && ber_sel_q[l] != BER_OFF) begin
            if (bit_clr[l]) begin
               bit_err_q[l] <= 16'(count_ones(line_in[l], ber_sel_q[l]));
            end else if ({1'b0, bit_err_q[l]} + 17'(count_ones(line_in[l], ber_sel_q[l])) > 17'(BIT_ERR_MAX)) begin
               bit_err_q[l] <= BIT_ERR_MAX;
            end else begin
               bit_err_q[l] <= bit_err_q[l] + 16'(count_ones(line_in[l], ber_sel_q[l]));
            end
         end else if (bit_clr[l]) begin
            bit_err_q[l] <= 16'h0000;
         end
      end
   end

endmodule

// ### lmtu_line_maint_properties.sv
`timescale 1ns/1ps
module lmtu_line_maint_chk
   import lmtu_pkg::*;
#(
   parameter int PULSE_CYCLES = 20
) (
   input wire logic       clk_sys,
   input wire logic       rst_n,
   input wire logic       wb_cyc_i,
   input wire logic       wb_stb_i,
   input wire logic       wb_ack_o,
   input wire logic       cmd_valid,
   input wire logic [1:0] cmd_line,
   input wire logic [3:0] cmd_code,
   input wire logic       mon_rd_valid,
   input wire logic       mon_rd_ack,
   input wire logic [3:0] frame_strobe,
   input wire logic [3:0] tx_m_plus,
   input wire logic [3:0] tx_enable,
   input wire logic [3:0] analog_loop_en,
   input wire logic [3:0] far_end_ignore,
   input wire logic [3:0] force_transparent,
   input wire logic [3:0] single_pulse_tx
);
   logic [31:0] gap_q;
   logic        seen_q;

   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   // cycles since the last single pulse on line 0
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         gap_q  <= 32'h0;
         seen_q <= 1'b0;
      end else begin
         gap_q  <= single_pulse_tx[0] ? 32'h0 : gap_q + 32'h1;
         seen_q <= single_pulse_tx[0] | (seen_q & !tx_enable[0]);
      end
   end

   wb_ack_pulse_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("wishbone ack is not one pulse");
   mon_ack_pulse_a: assert property (mon_rd_valid |=> mon_rd_ack ##1 !mon_rd_ack)
      else $error("monitor read not answered");
   analog_loop_on_a: assert property (cmd_valid && cmd_code == CMD_ANALOG_LOOP_REQUEST
      |-> ##2 analog_loop_en[$past(cmd_line, 2)]) else $error("analog loop not closed");
   loop_ignores_far_a: assert property ((analog_loop_en & ~far_end_ignore) == 4'h0)
      else $error("far end data not ignored in loop");
   loop_keeps_tx_a: assert property ((analog_loop_en & ~tx_enable) == 4'h0)
      else $error("line signal stopped during loop");
   dt_transparent_a: assert property (cmd_valid && cmd_code == CMD_DATA_THROUGH_MODE
      |-> ##2 force_transparent[$past(cmd_line, 2)]) else $error("data through not forced");
   other_lines_a: assert property (cmd_valid && cmd_code == CMD_ANALOG_LOOP_REQUEST |-> ##2
      ((analog_loop_en ^ $past(analog_loop_en, 2)) & ~(4'h1 << $past(cmd_line, 2))) == 4'h0)
      else $error("command changed another line");
   m_on_frame_a: assert property (((tx_m_plus ^ $past(tx_m_plus)) & ~$past(frame_strobe)) == 4'h0)
      else $error("m symbol changed off a frame");
   pulse_gap_a: assert property (single_pulse_tx[0] && seen_q |-> gap_q == PULSE_CYCLES - 1)
      else $error("single pulse spacing wrong");

   cover property (analog_loop_en[0]);
   cover property (single_pulse_tx[0] && seen_q);
   cover property (tx_m_plus[0] ##1 !tx_m_plus[0]);
   cover property (mon_rd_ack);
endmodule

bind lmtu_line_maint lmtu_line_maint_chk #(.PULSE_CYCLES(PULSE_CYCLES)) chk (.*);

// ### lmtu_far_end.sv
`timescale 1ns/1ps
module lmtu_far_end
   import lmtu_pkg::*;
#(
   parameter int FRAME_CYCLES = 16
) (
   input  wire logic          clk_sys,
   input  wire logic          rst_n,
   input  wire logic          cv_req,
   input  wire logic          mplus_req,
   input  wire logic [7:0]    err_b1,
   input  wire lmtu_chan_type line_out [LMTU_LINES],
   input  wire logic [3:0]    tx_m_plus,
   output logic [3:0]         frame_strobe,
   output logic [3:0]         frame_code_violation,
   output logic [3:0]         rx_m_plus,
   output lmtu_chan_type      line_in [LMTU_LINES]
);
   localparam lmtu_chan_type FAR_DATA = '{b1: 8'hC3, b2: 8'h3C, d: 2'h1};
   logic [7:0] tick_q;
   logic [3:0] run_q [LMTU_LINES];
   logic [3:0] last_q;
   logic [3:0] closed_q;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tick_q       <= 8'h00;
         frame_strobe <= 4'h0;
      end else begin
         tick_q       <= (tick_q == 8'(FRAME_CYCLES - 1)) ? 8'h00 : tick_q + 8'h01;
         frame_strobe <= {4{tick_q == 8'(FRAME_CYCLES - 1)}};
      end
   end

   // terminating loop two follows runs of equal m symbols
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         last_q   <= 4'h0;
         closed_q <= 4'h0;
         run_q    <= '{default: 4'h0};
      end else if (frame_strobe[0]) begin
         last_q <= tx_m_plus;
         for (int i = 0; i < LMTU_LINES; i++) begin
            run_q[i] <= (tx_m_plus[i] != last_q[i]) ? 4'h1 : run_q[i] + 4'(run_q[i] < 4'h8);
            if (run_q[i] >= 4'h7 && tx_m_plus[i] == last_q[i]) begin
               closed_q[i] <= tx_m_plus[i];
            end
         end
      end
   end

   always_comb begin
      for (int i = 0; i < LMTU_LINES; i++) begin
         line_in[i]    = closed_q[i] ? line_out[i] : FAR_DATA;
         line_in[i].b1 = line_in[i].b1 | err_b1;
      end
   end
   assign frame_code_violation = {4{cv_req}};
   assign rx_m_plus            = {4{mplus_req}};
endmodule

// ### line_maintenance_test_unit_bench.sv
`timescale 1ns/1ps
module line_maintenance_test_unit_bench
   import lmtu_pkg::*;
;
   typedef struct packed {
      logic [3:0] code;
      logic [2:0] mode;
      logic       an;
      logic       ft;
      logic       te;
      logic       mp;
   } lmtu_row_type;
   localparam int PULSE = 20;
   logic          clk_sys, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, cmd_valid, mon_rd_valid, mon_rd_ack;
   logic          single_pulse_pin, data_through_pin, digital_if_active, cv_req, mplus_req;
   logic [1:0]    cmd_line, mon_rd_line;
   logic [3:0]    cmd_code, frame_strobe, frame_code_violation, rx_m_plus, tx_m_plus, tx_enable;
   logic [3:0]    analog_loop_en, far_end_ignore, force_transparent, single_pulse_tx, activation_block;
   logic [7:0]    wb_adr_i, mon_rd_data, err_b1;
   logic [31:0]   wb_dat_i, wb_dat_o, rd;
   logic [2:0]    act_state [LMTU_LINES];
   lmtu_chan_type sys_in [LMTU_LINES], sys_out [LMTU_LINES], line_in [LMTU_LINES], line_out [LMTU_LINES];
   int            num_errors = 0, check_count = 0, i, k;
   lmtu_row_type  rows [8] = '{'{4'hA, 3'h1, 1'h0, 1'h0, 1'h1, 1'h1}, '{4'hF, 3'h1, 1'h0, 1'h0, 1'h1, 1'h1},
      '{4'h9, 3'h3, 1'h0, 1'h0, 1'h1, 1'h0}, '{4'h2, 3'h2, 1'h1, 1'h0, 1'h1, 1'h0},
      '{4'h0, 3'h0, 1'h0, 1'h0, 1'h1, 1'h0}, '{4'h5, 3'h6, 1'h0, 1'h0, 1'h0, 1'h0},
      '{4'h6, 3'h7, 1'h0, 1'h1, 1'h1, 1'h0}, '{4'h8, 3'h0, 1'h0, 1'h0, 1'h1, 1'h0}};

   lmtu_line_maint #(.PULSE_CYCLES(PULSE)) dut (.*, .wb_sel_i(4'hF));
   lmtu_far_end far (.*);
   always #10 clk_sys = ~clk_sys;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
      do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'h0;
   endtask
   task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      check(rd & m, e);
   endtask
   task automatic frames(input int n);
      repeat (n) begin
         do @(posedge clk_sys); while (frame_strobe[0] !== 1'b1);
      end
   endtask
   task automatic cmd(input logic [1:0] ln, input logic [3:0] c);
      frames(1);
      {cmd_valid, cmd_line, cmd_code} <= {1'b1, ln, c};
      @(posedge clk_sys);
      cmd_valid <= 1'b0;
   endtask
   // far end disturbance {err_b1, cv_req, mplus_req} held for n frames
   task automatic inject(input int n, input logic [9:0] v);
      frames(1);
      {err_b1, cv_req, mplus_req} <= v;
      frames(n);
      {err_b1, cv_req, mplus_req} <= 10'h000;
   endtask
   task automatic mon(input logic [31:0] e);
      @(posedge clk_sys);
      mon_rd_valid <= 1'b1;
      @(posedge clk_sys);
      mon_rd_valid <= 1'b0;
      @(posedge clk_sys);
      check({mon_rd_ack, mon_rd_data}, {1'b1, e[7:0]});
   endtask
   task automatic results;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      #400000;
      num_errors++;
      results();
   end

   initial begin
      {clk_sys, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, cmd_valid, mon_rd_valid} = 7'h00;
      {single_pulse_pin, data_through_pin, digital_if_active, cv_req, mplus_req} = 5'h00;
      {cmd_line, mon_rd_line, cmd_code, wb_adr_i, wb_dat_i, err_b1} = '0;
      for (i = 0; i < LMTU_LINES; i++) begin
         sys_in[i] = '0;
         act_state[i] = ACT_TRANSPARENT;
      end
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      #1;
      check(sys_out[0], CHAN_IDLE);
      check(tx_m_plus, 4'h0);
      rdm(8'hFC, 32'hFFFFFFFF, 32'h0);
      $display("reset test done");
      for (k = 0; k < 8; k++) begin
         cmd(2'h0, rows[k].code);
         frames(2);
         rdm(REG_STATUS, 32'h7, rows[k].mode);
         check(analog_loop_en[0], rows[k].an);
         check(force_transparent[0], rows[k].ft);
         check(tx_enable[0], rows[k].te);
         check(tx_m_plus[0], rows[k].mp);
         if (rows[k].an) begin
            check(sys_out[0].b1, 8'h00);
         end
      end
      $display("command table done");
      cmd(2'h0, CMD_REPEATER_LOOP_REQUEST);
      for (k = 0; k < 10; k++) begin
         frames(1);
         #1;
         check(tx_m_plus[0], k < 8 && k % 2 == 0);
      end
      $display("repeater test done");
      cmd(2'h0, CMD_NT_LOOP_TWO_REQUEST);
      frames(12);
      rdm(REG_STATUS, 32'h80, 32'h80);
      wb(1'b0, REG_BIT_ERR_LO, 32'h0);
      wb(1'b1, REG_ERR_CHAN_SELECT, {30'h0, BER_ALL});
      inject(3, 10'h004);
      frames(2);
      wb(1'b1, REG_ERR_CHAN_SELECT, {30'h0, BER_OFF});
      inject(2, 10'h004);
      rdm(REG_BIT_ERR_LO, 32'hFF, 32'h3);
      rdm(REG_BIT_ERR_HI, 32'hFF, 32'h0);
      rdm(REG_BIT_ERR_LO, 32'hFF, 32'h0);
      cmd(2'h0, CMD_DEACTIVATION_REQUEST);
      frames(1);
      #1;
      check(tx_m_plus[0], 1'b0);
      $display("bit error test done");
      mon(32'h0);
      inject(3, 10'h002);
      inject(2, 10'h001);
      mon(32'h5);
      inject(1, 10'h002);
      rdm(REG_BLOCK_ERR, 32'hFF, 32'h1);
      rdm(REG_BLOCK_ERR, 32'hFF, 32'h0);
      inject(260, 10'h002);
      rdm(REG_BLOCK_ERR, 32'hFF, 32'hFF);
      act_state[0] <= ACT_DEACTIVATED;
      inject(2, 10'h002);
      rdm(REG_BLOCK_ERR, 32'hFF, 32'h0);
      $display("block error test done");
      wb(1'b1, REG_LOOP, 32'h01);
      frames(2);
      check(sys_out[0], {8'h00, 8'h3C, 2'h1});
      check(line_out[0], {8'hFF, 8'h00, 2'h0});
      wb(1'b1, REG_LOOP, 32'h09);
      frames(2);
      check(sys_out[0], {8'hFF, 8'h3C, 2'h1});
      check(line_out[0], {8'hC3, 8'h00, 2'h0});
      wb(1'b1, REG_LOOP, 32'h1 << LOOP_FRAMER);
      repeat (3) @(posedge clk_sys);
      check(activation_block[0], 1'b1);
      single_pulse_pin <= 1'b1;
      repeat (5) @(posedge clk_sys);
      check(tx_enable, 4'hF);
      digital_if_active <= 1'b1;
      repeat (5) @(posedge clk_sys);
      check(tx_enable, 4'h0);
      do @(posedge clk_sys); while (single_pulse_tx[0] !== 1'b1);
      k = 0;
      do begin
         @(posedge clk_sys);
         k++;
      end while (single_pulse_tx[0] !== 1'b1);
      check(k, PULSE);
      {single_pulse_pin, data_through_pin} <= 2'h1;
      repeat (5) @(posedge clk_sys);
      check(force_transparent, 4'hF);
      cmd(2'h1, CMD_ANALOG_LOOP_REQUEST);
      repeat (3) @(posedge clk_sys);
      check(analog_loop_en, 4'h2);
      $display("loop and pin tests done");
      results();
   end
endmodule
